//--- logic/phy_fc_consts.vh
`ifndef PHY_FC_CONSTS_VH
`define PHY_FC_CONSTS_VH

// ********************************************************************
// Register addresses (6-bit ULPI register space)
// ********************************************************************
`define FC_ADDR_WRITE      6'h04
`define FC_ADDR_SET        6'h05
`define FC_ADDR_CLEAR      6'h06

// ********************************************************************
// Field positions
// ********************************************************************
`define FC_BIT_RESERVED    7
`define FC_BIT_LOW_POWER_N 6
`define FC_BIT_CORE_RESET  5
`define FC_OPSEL_HI        4
`define FC_OPSEL_LO        3
`define FC_BIT_TERM        2
`define FC_SPEED_HI        1
`define FC_SPEED_LO        0

// ********************************************************************
// Reset value and field encodings
// ********************************************************************
`define FC_RESET_VALUE     8'h41
`define OPSEL_NORMAL       2'h0
`define OPSEL_NON_DRIVING  2'h1
`define OPSEL_NO_STUFF     2'h2
`define OPSEL_NO_SYNC_EOP  2'h3
`define SPEED_HIGH         2'h0
`define SPEED_FULL         2'h1
`define SPEED_LOW          2'h2
`define SPEED_LOW_ON_FULL  2'h3

// ********************************************************************
// Timing: core reset duration in ns, and in 4 ns clock cycles
// ********************************************************************
`define CORE_RESET_NS      100
`define CLK_PERIOD_NS      4
`define CORE_RESET_CYCLES  \
    ((`CORE_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- logic/core_reset_timer.v
`include "phy_fc_consts.vh"

// ********************************************************************
// Counts the digital core reset duration after a start pulse
// ********************************************************************
module core_reset_timer
#(
    parameter CYCLES = `CORE_RESET_CYCLES
)
(
    input  wire sys_clk_i,
    input  wire sys_rst_i,
    input  wire start_i,
    output wire busy_o,
    output wire done_o
);
    reg [15:0] count_reg;
    reg        busy_reg;
    reg        done_reg;

    // Load on start, count down, pulse done at zero
    always @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            count_reg <= 16'h0000;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
        end
        else
        begin
            done_reg <= 1'b0;
            if (start_i && !busy_reg)
            begin
                count_reg <= CYCLES[15:0] - 16'h0001;
                busy_reg  <= 1'b1;
            end
            else if (busy_reg)
            begin
                if (count_reg == 16'h0000)
                begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end
                else
                    count_reg <= count_reg - 16'h0001;
            end
        end
    end

    assign busy_o = busy_reg;
    assign done_o = done_reg;
endmodule // core_reset_timer

//--- logic/ulpi_phy_function_control.v
`include "phy_fc_consts.vh"

module ulpi_phy_function_control
#(
    parameter RESET_CYCLES = `CORE_RESET_CYCLES
)
(
    input  wire       sys_clk_i,
    input  wire       sys_rst_i,
    // Register write port from the ULPI register engine
    input  wire       reg_wr_i,
    input  wire [5:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    output wire [7:0] reg_rdata_o,
    // Link wake-up request (STP while in low power)
    input  wire       stp_i,
    // Resistor controls from the OTG control register
    input  wire       dplus_pull_low_en_i,
    input  wire       dminus_pull_low_en_i,
    // Bus direction and RXCMD update request
    output wire       dir_o,
    output wire       rxcmd_update_o,
    // Transceiver controls
    output wire       low_power_o,
    output wire       core_reset_o,
    output wire       hs_xcvr_en_o,
    output wire       fs_xcvr_en_o,
    output wire       ls_xcvr_en_o,
    output wire       ls_preamble_en_o,
    output wire       tx_non_driving_o,
    output wire       tx_no_stuff_nrzi_o,
    output wire       tx_no_sync_eop_o,
    output wire       fs_pullup_en_o,
    output wire       hs_term_en_o
);
    // ****************************************************************
    // Register and state
    // ****************************************************************
    localparam ST_IDLE  = 3'b001;
    localparam ST_RESET = 3'b010;
    localparam ST_CMD   = 3'b100;

    reg  [7:0] function_control_reg;
    reg  [7:0] function_control_next;
    reg  [2:0] state_reg;
    reg  [2:0] state_next;
    reg        rxcmd_reg;
    reg  [7:0] ctrl_out_reg;
    wire       timer_busy;
    wire       timer_done;
    wire       start_reset;

    wire [1:0] tx_operation_select;
    wire [1:0] transceiver_speed_select;
    wire       termination_select;
    wire       low_power_n;

    assign low_power_n              =
        function_control_reg[`FC_BIT_LOW_POWER_N];
    assign tx_operation_select      =
        function_control_reg[`FC_OPSEL_HI:`FC_OPSEL_LO];
    assign transceiver_speed_select =
        function_control_reg[`FC_SPEED_HI:`FC_SPEED_LO];
    assign termination_select       = function_control_reg[`FC_BIT_TERM];

    // Start the core reset once, from idle, on the bit being seen set
    assign start_reset = (state_reg == ST_IDLE) &&
                         function_control_reg[`FC_BIT_CORE_RESET];

    // ****************************************************************
    // Register write, set, clear and hardware updates
    // ****************************************************************
    // Hardware updates are applied after software so they always win
    always @*
    begin
        function_control_next = function_control_reg;
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                `FC_ADDR_WRITE:
                    function_control_next = reg_wdata_i;
                `FC_ADDR_SET:
                    function_control_next = function_control_reg
                                            | reg_wdata_i;
                `FC_ADDR_CLEAR:
                    function_control_next = function_control_reg
                                            & ~reg_wdata_i;
                default:
                    function_control_next = function_control_reg;
            endcase
        end
        // STP wakes the PHY; the bit returns to powered on its own
        if (!low_power_n && stp_i)
            function_control_next[`FC_BIT_LOW_POWER_N] = 1'b1;
        // Self-clear of the reset bit when the core reset completes
        if (timer_done)
            function_control_next[`FC_BIT_CORE_RESET] = 1'b0;
    end

    // Register file survives the core reset; only sys_rst_i reloads it, with FC_RESET_VALUE
    always @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            function_control_reg <= `FC_RESET_VALUE;
        else
            function_control_reg <= function_control_next;
    end

    // ****************************************************************
    // Core reset sequence
    // ****************************************************************
    core_reset_timer
    #(
        .CYCLES (RESET_CYCLES)
    )
    u_timer
    (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (start_reset),
        .busy_o    (timer_busy),
        .done_o    (timer_done)
    );

    // Idle, hold DIR during reset, then one RXCMD update
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                if (start_reset)
                    state_next = ST_RESET;
            ST_RESET:
                if (timer_done)
                    state_next = ST_CMD;
            ST_CMD:
                state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    always @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_reg <= ST_IDLE;
            rxcmd_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            rxcmd_reg <= (state_next == ST_CMD);
        end
    end

    // Link relies on DIR to know when the bus is usable again
    assign dir_o          = (state_reg == ST_RESET);
    assign core_reset_o   = timer_busy;
    assign rxcmd_update_o = rxcmd_reg;
    assign reg_rdata_o    = function_control_reg;

    // ****************************************************************
    // Transceiver control decode (bit 7 deliberately unused)
    // ****************************************************************
    // Registered so that the speed and operation decodes change together
    always @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            ctrl_out_reg <= 8'h00;
        else
        begin
            ctrl_out_reg[0] <=
                (transceiver_speed_select == `SPEED_HIGH);
            ctrl_out_reg[1] <=
                (transceiver_speed_select == `SPEED_FULL) ||
                (transceiver_speed_select == `SPEED_LOW_ON_FULL);
            ctrl_out_reg[2] <=
                (transceiver_speed_select == `SPEED_LOW);
            ctrl_out_reg[3] <=
                (transceiver_speed_select == `SPEED_LOW_ON_FULL);
            ctrl_out_reg[4] <=
                (tx_operation_select == `OPSEL_NON_DRIVING);
            ctrl_out_reg[5] <=
                (tx_operation_select == `OPSEL_NO_STUFF);
            ctrl_out_reg[6] <=
                (tx_operation_select == `OPSEL_NO_SYNC_EOP);
            ctrl_out_reg[7] <= 1'b0;
        end
    end

    // HS and LS transceivers powered down whenever the active-low suspend bit is zero
    assign low_power_o        = ~low_power_n;
    assign hs_xcvr_en_o       = ctrl_out_reg[0] & low_power_n;
    assign fs_xcvr_en_o       = ctrl_out_reg[1];
    assign ls_xcvr_en_o       = ctrl_out_reg[2] & low_power_n;
    assign ls_preamble_en_o   = ctrl_out_reg[3];
    assign tx_non_driving_o   = ctrl_out_reg[4];
    assign tx_no_stuff_nrzi_o = ctrl_out_reg[5];
    assign tx_no_sync_eop_o   = ctrl_out_reg[6];

    // Simplified resistor table: pulldowns both on means host role
    assign fs_pullup_en_o = termination_select &&
        !(dplus_pull_low_en_i && dminus_pull_low_en_i) &&
        (transceiver_speed_select != `SPEED_HIGH) &&
        (tx_operation_select != `OPSEL_NON_DRIVING);
    assign hs_term_en_o   = !termination_select &&
        (transceiver_speed_select == `SPEED_HIGH) &&
        (tx_operation_select != `OPSEL_NON_DRIVING) && low_power_n;
endmodule // ulpi_phy_function_control

//--- test/link_model.sv
// ****************************************************************
// Link controller: register writes and wake-up on STP
// ****************************************************************
module link_model
(
    input  wire logic       sys_clk_i,
    input  wire logic       dir_i,
    output logic            wr_o,
    output logic [5:0]      addr_o,
    output logic [7:0]      wdata_o,
    output logic            stp_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle values at time zero
    initial
    begin
        wr_o = 1'b0;
        addr_o = 6'h00;
        wdata_o = 8'h00;
        stp_o = 1'b0;
    end

    // One write; never starts while DIR is high
    // Only function control is touched, so one interface mode
    task automatic write(input logic [5:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        #1;
        // DIR read after it settles, not in the edge's own time step
        while (dir_i)
        begin
            @(posedge sys_clk_i);
            #1;
        end
        wr_o = 1'b1;
        addr_o = a;
        wdata_o = d;
        @(posedge sys_clk_i);
        #1;
        wr_o = 1'b0;
        addr_o = ~a; // Released lines do not keep old value
        wdata_o = ~d;
    endtask

    // Wake from low power with STP, not by a write
    task automatic wake();
        @(posedge sys_clk_i);
        #1 stp_o = 1'b1;
        @(posedge sys_clk_i);
        #1 stp_o = 1'b0;
    endtask
endmodule // link_model

//--- test/fc_asserts.sv
// ****************************************************************
// Port checker for the function control block
// ****************************************************************
module fc_asserts
#(
    parameter RESET_CYCLES = 25
)
(
    input wire logic       sys_clk_i,
    input wire logic       sys_rst_i,
    input wire logic       reg_wr_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       stp_i,
    input wire logic       dir_o,
    input wire logic       rxcmd_update_o,
    input wire logic       low_power_o,
    input wire logic       hs_xcvr_en_o,
    input wire logic       ls_preamble_en_o,
    input wire logic       tx_no_sync_eop_o,
    input wire logic       hs_term_en_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic [7:0] dir_cnt_reg;
    logic       idle;

    // Cycles of DIR high; the length must be the timer parameter plus one
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
        if (sys_rst_i) dir_cnt_reg <= 8'h00;
        else dir_cnt_reg <= dir_o ? dir_cnt_reg + 8'h01 : 8'h00;
    assign idle = !dir_o && !stp_i;

    chk_write_whole: assert property (
        reg_wr_i && reg_addr_i == 6'h04 && idle
        |=> reg_rdata_o == $past(reg_wdata_i)) else $error("write lost");
    chk_set_or: assert property (
        reg_wr_i && reg_addr_i == 6'h05 && idle
        |=> reg_rdata_o == $past(reg_rdata_o | reg_wdata_i))
        else $error("set lost");
    chk_clear_mask: assert property (
        reg_wr_i && reg_addr_i == 6'h06 && idle
        |=> reg_rdata_o == $past(reg_rdata_o & ~reg_wdata_i))
        else $error("clear lost");
    chk_low_power: assert property (
        low_power_o == !reg_rdata_o[6]) else $error("low power flag wrong");
    chk_wake_sets: assert property (
        !reg_rdata_o[6] && stp_i |=> reg_rdata_o[6]) else $error("no wake");
    chk_reset_dir: assert property (
        $rose(reg_rdata_o[5]) && !dir_o |=> dir_o)
        else $error("DIR not raised");
    chk_dir_length: assert property (
        $fell(dir_o) |-> dir_cnt_reg == RESET_CYCLES + 1)
        else $error("DIR length");
    chk_reset_end: assert property (
        $fell(dir_o) |-> !reg_rdata_o[5] ##[0:1] rxcmd_update_o)
        else $error("no self clear");
    chk_rxcmd_pulse: assert property (
        rxcmd_update_o |=> !rxcmd_update_o) else $error("rxcmd too long");
    // Decode is one cycle late, but the power gate acts at once
    chk_speed_decode: assert property (
        1'b1 |=> {hs_xcvr_en_o, ls_preamble_en_o} ==
        {$past(reg_rdata_o[1:0]) == 2'h0 && reg_rdata_o[6],
        $past(reg_rdata_o[1:0]) == 2'h3}) else $error("speed decode");
    chk_opsel_raw: assert property (
        1'b1 |=> tx_no_sync_eop_o == ($past(reg_rdata_o[4:3]) == 2'h3))
        else $error("opsel");
    // No HS terminations while non-driving or powered down
    chk_hs_term: assert property (
        hs_term_en_o == (!reg_rdata_o[2] && reg_rdata_o[1:0] == 2'h0 &&
        reg_rdata_o[4:3] != 2'h1 && reg_rdata_o[6])) else $error("hs term");

    // Main scenarios reached
    cov_core_reset: cover property ($fell(dir_o));
    cov_wake: cover property (!reg_rdata_o[6] && stp_i);
    cov_set: cover property (reg_wr_i && reg_addr_i == 6'h05);
endmodule // fc_asserts

bind ulpi_phy_function_control fc_asserts #(.RESET_CYCLES(RESET_CYCLES))
    u_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .stp_i(stp_i),
    .dir_o(dir_o), .rxcmd_update_o(rxcmd_update_o),
    .low_power_o(low_power_o), .hs_xcvr_en_o(hs_xcvr_en_o),
    .ls_preamble_en_o(ls_preamble_en_o),
    .tx_no_sync_eop_o(tx_no_sync_eop_o), .hs_term_en_o(hs_term_en_o));

//--- test/test_ulpi_phy_function_control.sv
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module test_ulpi_phy_function_control;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int RC = 3; // Short core reset keeps the run brief
    logic sys_clk_i, sys_rst_i, dp, dm;
    wire wr, stp, dir, rxcmd, lp, crst, hs, fs, ls, pre, nd, nst, nse, pu, ht;
    wire [5:0] addr;
    wire [7:0] wdata, rdata;
    int failures = 0, checked = 0;

    ulpi_phy_function_control #(.RESET_CYCLES(RC)) dut (.sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i), .reg_wr_i(wr), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .stp_i(stp),
        .dplus_pull_low_en_i(dp), .dminus_pull_low_en_i(dm), .dir_o(dir),
        .rxcmd_update_o(rxcmd), .low_power_o(lp), .core_reset_o(crst),
        .hs_xcvr_en_o(hs), .fs_xcvr_en_o(fs), .ls_xcvr_en_o(ls),
        .ls_preamble_en_o(pre), .tx_non_driving_o(nd),
        .tx_no_stuff_nrzi_o(nst), .tx_no_sync_eop_o(nse),
        .fs_pullup_en_o(pu), .hs_term_en_o(ht));
    link_model link (.sys_clk_i(sys_clk_i), .dir_i(dir), .wr_o(wr),
        .addr_o(addr), .wdata_o(wdata), .stp_o(stp));

    // Clock and settling step
    initial
    begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    task automatic step(); @(posedge sys_clk_i); #1; endtask

    // Reset value, write, set, clear, unmapped address
    task automatic t_regs();
        `CHK(rdata, 8'h41)
        step();
        `CHK({fs, hs, ls}, 3'h4)
        link.write(6'h04, 8'hd6);
        link.write(6'h05, 8'h09);
        `CHK(rdata, 8'hdf)
        link.write(6'h06, 8'h96);
        link.write(6'h16, 8'hff);
        `CHK(rdata, 8'h49)
    endtask

    // Every speed and every operation code
    task automatic t_fields();
        for (int i = 0; i < 4; i++)
        begin
            link.write(6'h04, 8'h40 | 8'(i));
            step();
            `CHK({hs, fs, ls, pre}, {i == 0, i[0], i == 2, i == 3})
            `CHK(ht, 1'(i == 0))
        end
        for (int j = 0; j < 4; j++)
        begin
            link.write(6'h04, 8'h45 | 8'(j << 3));
            step();
            `CHK({nd, nst, nse}, {j == 1, j == 2, j == 3})
            `CHK(pu, 1'(j != 1))
        end
        dp = 1'b1;
        dm = 1'b1;
        step();
        `CHK(pu, 1'b0)
        dp = 1'b0;
        dm = 1'b0;
    endtask

    // Low power entry and wake by STP
    task automatic t_power();
        link.write(6'h04, 8'h00);
        `CHK(lp, 1'b1)
        step();
        `CHK(hs, 1'b0)
        link.wake();
        `CHK({rdata[6], lp}, 2'h2)
        step();
        `CHK(hs, 1'b1)
    endtask

    // Core reset keeps other bits, then self-clears
    task automatic t_reset();
        int n;
        link.write(6'h04, 8'h5a);
        link.write(6'h05, 8'h20);
        for (int k = 0; k < 4 && !dir; k++) step();
        `CHK({dir, crst}, 2'h3)
        n = 0;
        while (dir && n < 50)
        begin
            n++;
            step();
        end
        `CHK(n, RC + 1)
        `CHK(rdata, 8'h5a)
        for (int k = 0; k < 2 && !rxcmd; k++) step();
        `CHK(rxcmd, 1'b1)
    endtask

    // Reserved bit changes no transceiver control output
    task automatic t_bit7();
        logic [9:0] ref_v;
        link.write(6'h04, 8'h41);
        step();
        ref_v = {hs, fs, ls, pre, nd, nst, nse, pu, ht, lp};
        link.write(6'h04, 8'hc1);
        step();
        `CHK({hs, fs, ls, pre, nd, nst, nse, pu, ht, lp}, ref_v)
    endtask

    // Counts and verdict
    task automatic close_out();
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        sys_rst_i = 1'b1;
        dp = 1'b0;
        dm = 1'b0;
        repeat (4) @(posedge sys_clk_i);
        #1 sys_rst_i = 1'b0;
        t_regs();
        t_fields();
        t_power();
        t_reset();
        t_bit7();
        close_out();
    end

    // Watchdog, far beyond the fewer than 100 cycles needed
    initial
    begin
        #20000;
        failures++;
        close_out();
    end
endmodule // test_ulpi_phy_function_control
